// file: rtl/occ_console.sv
`timescale 1ns/100ps
`default_nettype none
module occ_console import occ_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  // Operator keys, one-cycle pulses except the console interrupt level
  input wire logic key_reset,
  input wire logic key_store,
  input wire logic key_data_buffer,
  input wire logic key_console_intr,
  input wire logic key_start,
  input wire logic key_stop,
  input wire logic key_sel_status,
  input wire logic key_sel_iword,
  input wire logic key_sel_exec,
  input wire logic key_sel_sal,
  input wire logic key_sel_main,
  input wire logic key_sel_lstat,
  input wire logic key_sel_ip,
  input wire logic key_sel_gpr,
  input wire logic [2:0] key_gpr_num,
  input wire logic key_sel_addr_key,
  input wire logic key_level,
  input wire logic [1:0] key_level_num,
  input wire logic key_hex,
  input wire logic [3:0] key_hex_val,
  // Operator indicators
  output logic [15:0] display_data,
  output logic [3:0] level_ind,
  output logic stop_ind,
  output logic tone,
  output logic console_irq,
  output logic [15:0] start_addr,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  occ_state_t proc_state;
  occ_sel_t sel;
  logic from_reset, from_wait, main_stored, irq_done;
  logic [1:0] cur_level;
  logic [2:0] gpr_sel;
  logic [3:0] int_mask;
  logic [15:0] console_buf, processor_status_word, instruction_word_latch;
  logic [15:0] executed_instruction_pointer, storage_address_latch;
  logic [15:0] level_status_register [LEVELS];
  logic [15:0] instruction_pointer [LEVELS];
  logic [15:0] gpr [LEVELS*GPR_PER_LEVEL];
  logic [15:0] mem [MEM_WORDS];
  logic wr_pend;
  logic [7:0] wr_ofs;

  // Word index of a storage address
  function automatic logic [7:0] word_idx(input logic [15:0] a);
    return a[8:1];
  endfunction

  // Next storage address in sequence
  function automatic logic [15:0] advance(input logic [15:0] a);
    return 16'(a + STORAGE_STEP);
  endfunction

  // Decoded actions
  logic in_stop, running, stop_ok, st_store, bus_wait, bus_wake, bus_summary;
  logic eligible, start_ok, stop_entry, sel_key, store_tone;
  logic [4:0] gpr_idx, gpr_key_idx;
  logic [15:0] hex_next, sel_value;
  assign in_stop = proc_state == ST_STOP;
  assign running = proc_state == ST_RUN || proc_state == ST_WAIT;
  assign stop_ok = in_stop && !key_reset;
  assign st_store = key_store && stop_ok;
  assign start_ok = key_start && stop_ok;
  assign stop_entry = key_stop && running && !key_reset;
  assign hex_next = {display_data[11:0], key_hex_val};
  assign gpr_idx = {cur_level, gpr_sel};
  assign gpr_key_idx = {cur_level, key_gpr_num};
  assign sel_key = key_sel_status || key_sel_iword || key_sel_exec || key_sel_sal
                   || key_sel_main || key_sel_lstat || key_sel_ip || key_sel_gpr;
  assign store_tone = st_store && (sel == SEL_SAL || sel == SEL_MAIN
                      || sel == SEL_IP || sel == SEL_GPR);
  assign bus_wait = wr_pend && wr_ofs == OFS_CPU_EVENT && hwdata[EVT_WAIT_BIT];
  assign bus_wake = wr_pend && wr_ofs == OFS_CPU_EVENT && hwdata[EVT_WAKE_BIT];
  assign bus_summary = wr_pend && wr_ofs == OFS_SUMMARY;
  assign eligible = key_console_intr && running
                    && level_status_register[cur_level][LSTAT_SUM_BIT];

  // Value shown by a select key
  always_comb begin
    sel_value = console_buf;
    if (key_sel_status) sel_value = processor_status_word;
    else if (key_sel_iword) sel_value = instruction_word_latch;
    else if (key_sel_exec) sel_value = executed_instruction_pointer;
    else if (key_sel_sal) sel_value = storage_address_latch;
    else if (key_sel_main) begin
      if (sel == SEL_MAIN) sel_value = mem[word_idx(advance(storage_address_latch))];
      else sel_value = mem[word_idx(storage_address_latch)];
    end
    else if (key_sel_lstat) sel_value = level_status_register[cur_level];
    else if (key_sel_ip) sel_value = instruction_pointer[cur_level];
    else if (key_sel_gpr) sel_value = gpr[gpr_key_idx];
  end

  // Processor run state, level and start address
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      proc_state <= ST_STOP;
      from_reset <= 1'b1;
      from_wait <= 1'b0;
      cur_level <= 2'h0;
      level_ind <= 4'h0;
      stop_ind <= 1'b1;
      start_addr <= WORD_ZERO;
      executed_instruction_pointer <= WORD_ZERO;
    end else begin
      case (proc_state)
        ST_RESET: begin
          proc_state <= ST_STOP;
          stop_ind <= 1'b1;
        end
        ST_STOP: begin
          if (start_ok) begin
            if (from_reset) begin
              cur_level <= 2'h0;
              level_ind <= 4'h1;
              start_addr <= WORD_ZERO;
              proc_state <= ST_RUN;
            end else begin
              start_addr <= instruction_pointer[cur_level];
              proc_state <= from_wait ? ST_WAIT : ST_RUN;
            end
            stop_ind <= 1'b0;
            from_reset <= 1'b0;
            from_wait <= 1'b0;
          end else if (key_level && stop_ok) begin
            cur_level <= key_level_num;
            level_ind <= 4'(1 << key_level_num);
          end
        end
        ST_RUN: begin
          if (stop_entry) begin
            executed_instruction_pointer <= instruction_pointer[cur_level];
            proc_state <= ST_STOP;
            stop_ind <= 1'b1;
          end else if (bus_wait) begin
            proc_state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (stop_entry) begin
            proc_state <= ST_STOP;
            from_wait <= 1'b1;
            stop_ind <= 1'b1;
          end else if (bus_wake) begin
            proc_state <= ST_RUN;
          end
        end
        default: proc_state <= ST_STOP;
      endcase
      if (key_reset) begin
        proc_state <= ST_RESET;
        from_reset <= 1'b1;
        from_wait <= 1'b0;
        cur_level <= 2'h0;
        level_ind <= 4'h1;
        executed_instruction_pointer <= WORD_ZERO;
      end
    end
  end

  // Selection and display contents
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      display_data <= POWER_DISPLAY;
      sel <= SEL_NONE;
      gpr_sel <= 3'h0;
      main_stored <= 1'b0;
    end else if (key_reset) begin
      display_data <= WORD_ZERO;
      sel <= SEL_NONE;
      main_stored <= 1'b0;
    end else if (key_hex) begin
      display_data <= hex_next;
    end else if (key_data_buffer) begin
      display_data <= console_buf;
      sel <= SEL_NONE;
    end else if (stop_entry) begin
      display_data <= instruction_pointer[cur_level];
      sel <= SEL_NONE;
    end else if (start_ok) begin
      display_data <= console_buf;
      sel <= SEL_NONE;
    end else if (stop_ok && sel_key) begin
      display_data <= sel_value;
      main_stored <= 1'b0;
      if (key_sel_status) sel <= SEL_STATUS;
      else if (key_sel_iword) sel <= SEL_IWORD;
      else if (key_sel_exec) sel <= SEL_EXEC;
      else if (key_sel_sal) sel <= SEL_SAL;
      else if (key_sel_main) sel <= SEL_MAIN;
      else if (key_sel_lstat) sel <= SEL_LSTAT;
      else if (key_sel_ip) sel <= SEL_IP;
      else sel <= SEL_GPR;
      gpr_sel <= key_gpr_num;
    end else if (key_sel_addr_key && stop_ok) begin
      sel <= SEL_ADDR_KEY;
    end else if (st_store && sel == SEL_MAIN) begin
      if (main_stored) begin
        display_data <= mem[word_idx(advance(storage_address_latch))];
      end
      main_stored <= 1'b1;
    end
  end

  // Console data buffer, kept across console reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      console_buf <= WORD_ZERO;
    end else if (key_hex && !key_reset) begin
      console_buf <= hex_next;
    end
  end

  // Storage address latch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      storage_address_latch <= WORD_ZERO;
    end else if (key_reset) begin
      storage_address_latch <= WORD_ZERO;
    end else if (st_store && sel == SEL_SAL) begin
      storage_address_latch <= {storage_address_latch[TOP_BIT] & console_buf[TOP_BIT],
                                console_buf[TOP_BIT-1:0]};
    end else if ((st_store && sel == SEL_MAIN && main_stored)
                 || (stop_ok && key_sel_main && sel == SEL_MAIN)) begin
      storage_address_latch <= advance(storage_address_latch);
    end
  end

  // Main storage, untouched by any reset
  always_ff @(posedge clk_sys) begin
    if (st_store && sel == SEL_MAIN && !main_stored) begin
      mem[word_idx(storage_address_latch)] <= console_buf;
    end
  end

  // General registers of every level, untouched by any reset
  always_ff @(posedge clk_sys) begin
    if (st_store && sel == SEL_GPR) begin
      gpr[gpr_idx] <= console_buf;
    end
  end

  // Instruction pointers per level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < LEVELS; i++) begin
        instruction_pointer[i] <= WORD_ZERO;
      end
    end else if (key_reset) begin
      instruction_pointer[0] <= WORD_ZERO;
    end else if (st_store && sel == SEL_IP) begin
      instruction_pointer[cur_level] <= {instruction_pointer[cur_level][TOP_BIT],
                                         console_buf[TOP_BIT-1:0]};
    end
  end

  // Level status registers; console stores never reach them
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      level_status_register[0] <= LSTAT0_RESET;
      for (int i = 1; i < LEVELS; i++) begin
        level_status_register[i] <= WORD_ZERO;
      end
    end else if (key_reset) begin
      level_status_register[0] <= LSTAT0_RESET;
      for (int i = 1; i < LEVELS; i++) begin
        level_status_register[i] <= WORD_ZERO;
      end
    end else if (bus_summary) begin
      level_status_register[cur_level][LSTAT_SUM_BIT] <= hwdata[0];
    end
  end

  // Program-written mask, status word and instruction latch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      int_mask <= INT_MASK_RESET;
      processor_status_word <= WORD_ZERO;
      instruction_word_latch <= WORD_ZERO;
    end else if (key_reset) begin
      int_mask <= INT_MASK_RESET;
      processor_status_word <= WORD_ZERO;
    end else if (wr_pend) begin
      if (wr_ofs == OFS_INT_MASK) int_mask <= hwdata[3:0];
      if (wr_ofs == OFS_STATUS_WORD) processor_status_word <= hwdata[15:0];
      if (wr_ofs == OFS_IWORD) instruction_word_latch <= hwdata[15:0];
    end
  end

  // Acceptance tone, one pulse per serviced key except the address key and the console interrupt key
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tone <= 1'b0;
    end else begin
      tone <= key_reset || key_hex || key_data_buffer || start_ok || stop_entry
              || (stop_ok && (sel_key || key_level)) || store_tone;
    end
  end

  // Console interrupt, once per key hold
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      console_irq <= 1'b0;
      irq_done <= 1'b0;
    end else begin
      console_irq <= eligible && !irq_done;
      if (!key_console_intr) irq_done <= 1'b0;
      else if (eligible) irq_done <= 1'b1;
    end
  end

  // Register read mux
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h00000000;
    if (haddr[31:5] == MAP_HIGH) begin
      case (haddr[7:0])
        OFS_STATUS: rd_word = {26'h0, from_wait, from_reset, cur_level, proc_state};
        OFS_DISPLAY: rd_word = {16'h0000, display_data};
        OFS_CONS_BUF: rd_word = {16'h0000, console_buf};
        OFS_SUMMARY: rd_word = {31'h0, level_status_register[cur_level][LSTAT_SUM_BIT]};
        OFS_INT_MASK: rd_word = {28'h0, int_mask};
        OFS_STATUS_WORD: rd_word = {16'h0000, processor_status_word};
        OFS_IWORD: rd_word = {16'h0000, instruction_word_latch};
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= hsel && hready && htrans[1] && hwrite && haddr[31:5] == MAP_HIGH;
      wr_ofs <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) hrdata <= rd_word;
    end
  end

  // Checks
  property p_mask_all; @(posedge clk_sys) disable iff (rst)
    key_reset |=> int_mask == INT_MASK_RESET; endproperty
  a_mask_all: assert property (p_mask_all) else $error("mask not all enabled");
  property p_lstat0; @(posedge clk_sys) disable iff (rst)
    key_reset |=> level_status_register[0] == LSTAT0_RESET
                  && level_status_register[3] == WORD_ZERO; endproperty
  a_lstat0: assert property (p_lstat0) else $error("level status not reset");
  property p_clear; @(posedge clk_sys) disable iff (rst)
    key_reset |=> processor_status_word == WORD_ZERO && storage_address_latch == WORD_ZERO
                  && executed_instruction_pointer == WORD_ZERO
                  && instruction_pointer[0] == WORD_ZERO; endproperty
  a_clear: assert property (p_clear) else $error("reset left a register set");
  property p_stop_after; @(posedge clk_sys) disable iff (rst)
    key_reset ##1 !key_reset |=> in_stop && stop_ind; endproperty
  a_stop_after: assert property (p_stop_after) else $error("no stop after reset");
  property p_keep_ip1; @(posedge clk_sys) disable iff (rst)
    key_reset |=> instruction_pointer[1] == $past(instruction_pointer[1]); endproperty
  a_keep_ip1: assert property (p_keep_ip1) else $error("reset touched pointer 1");
  property p_no_run_store; @(posedge clk_sys) disable iff (rst)
    key_store && running && !key_hex && !key_data_buffer && !key_stop && !key_reset
    |=> !tone; endproperty
  a_no_run_store: assert property (p_no_run_store) else $error("store in run toned");
  property p_irq_stop; @(posedge clk_sys) disable iff (rst)
    in_stop |=> !console_irq; endproperty
  a_irq_stop: assert property (p_irq_stop) else $error("interrupt raised in stop");
  property p_irq_rise; @(posedge clk_sys) disable iff (rst)
    $rose(eligible) && !irq_done |=> console_irq ##1 !console_irq; endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("console interrupt missed");
  property p_hex; @(posedge clk_sys) disable iff (rst)
    key_hex && !key_reset |=> display_data == {$past(display_data[11:0]), $past(key_hex_val)};
  endproperty
  a_hex: assert property (p_hex) else $error("hex entry shift wrong");
  property p_sal15; @(posedge clk_sys) disable iff (rst)
    st_store && sel == SEL_SAL && !storage_address_latch[15] |=> !storage_address_latch[15];
  endproperty
  a_sal15: assert property (p_sal15) else $error("storage bit 15 set");
  property p_wait_back; @(posedge clk_sys) disable iff (rst)
    start_ok && from_wait && !from_reset |=> proc_state == ST_WAIT; endproperty
  a_wait_back: assert property (p_wait_back) else $error("start left wait");
  property p_start_zero; @(posedge clk_sys) disable iff (rst)
    start_ok && from_reset |=> start_addr == WORD_ZERO && cur_level == 2'h0
                              && proc_state == ST_RUN; endproperty
  a_start_zero: assert property (p_start_zero) else $error("start after reset not zero");
  property p_addr_key; @(posedge clk_sys) disable iff (rst)
    key_sel_addr_key && !key_hex && !key_data_buffer && !key_reset && !key_start && !key_stop
    && !key_store && !key_level && !sel_key |=> !tone; endproperty
  a_addr_key: assert property (p_addr_key) else $error("address key toned");
endmodule // occ_console
`default_nettype wire

// file: rtl/occ_pkg.sv
`default_nettype none
package occ_pkg;
  // Register offsets on the bus (byte addresses)
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_DISPLAY = 8'h04;
  localparam logic [7:0] OFS_CONS_BUF = 8'h08;
  localparam logic [7:0] OFS_SUMMARY = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam logic [7:0] OFS_STATUS_WORD = 8'h14;
  localparam logic [7:0] OFS_IWORD = 8'h18;
  localparam logic [7:0] OFS_CPU_EVENT = 8'h1C;
  // Upper address bits that must be zero for a mapped access
  localparam logic [26:0] MAP_HIGH = 27'h0000000;

  // Level status register fields
  localparam int LSTAT_SUM_BIT = 8;
  localparam int LSTAT_SUP_BIT = 9;
  localparam int LSTAT_INPROC_BIT = 10;
  localparam int LSTAT_TRACE_BIT = 11;
  localparam logic [15:0] LSTAT0_RESET = 16'h0700;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [3:0] INT_MASK_RESET = 4'hF;
  localparam logic [15:0] POWER_DISPLAY = 16'hFFFF;
  localparam int TOP_BIT = 15;
  localparam logic [15:0] STORAGE_STEP = 16'h0002;

  // CPU event register bits
  localparam int EVT_WAIT_BIT = 0;
  localparam int EVT_WAKE_BIT = 1;

  // Structure sizes
  localparam int LEVELS = 4;
  localparam int GPR_PER_LEVEL = 8;
  localparam int MEM_WORDS = 256;

  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_RESET} occ_state_t;
  typedef enum logic [3:0] {
    SEL_NONE, SEL_STATUS, SEL_IWORD, SEL_EXEC, SEL_SAL, SEL_MAIN,
    SEL_LSTAT, SEL_IP, SEL_GPR, SEL_ADDR_KEY
  } occ_sel_t;
endpackage
`default_nettype wire

// file: tb/occ_operator.sv
`timescale 1ns/100ps
`default_nettype none
// Operator at the console: one key per cycle, digit held with its key
module occ_operator (
  input wire logic clk_sys,
  output var logic [15:0] pulse,
  output var logic [3:0] val,
  output var logic intr
);
  // Idle keys at time zero
  initial begin
    pulse = 16'h0000;
    val = 4'h0;
    intr = 1'b0;
  end
  // One-cycle press; the digit lines wander once the key is let go
  task automatic press(input int idx, input logic [3:0] v);
    @(posedge clk_sys);
    pulse[idx] <= 1'b1;
    val <= v;
    @(posedge clk_sys);
    pulse <= 16'h0000;
    val <= ~v;
  endtask
  // Console interrupt key is held as a level
  task automatic hold(input logic on);
    @(posedge clk_sys);
    intr <= on;
  endtask
endmodule // occ_operator
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench import occ_pkg::*; ;
  localparam int KRST = 0, KSTO = 1, KBUF = 2, KSTA = 3, KSTP = 4, KSWD = 5, KIW = 6, KEX = 7;
  localparam int KSAL = 8, KMAIN = 9, KLST = 10, KIP = 11, KGPR = 12, KADK = 13, KLVL = 14;
  logic clk_sys, rst, hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, rd;
  wire logic [15:0] pulse, display_data, start_addr;
  wire logic [3:0] val, level_ind;
  wire logic intr, hreadyout, hresp, stop_ind, tone, console_irq;
  wire logic [31:0] hrdata;
  int bad_count, num_checks, tones, irqs, t0;
  occ_operator op (.clk_sys(clk_sys), .pulse(pulse), .val(val), .intr(intr));
  occ_console uut (.clk_sys(clk_sys), .rst(rst), .key_reset(pulse[0]), .key_store(pulse[1]),
    .key_data_buffer(pulse[2]), .key_console_intr(intr), .key_start(pulse[3]),
    .key_stop(pulse[4]), .key_sel_status(pulse[5]), .key_sel_iword(pulse[6]),
    .key_sel_exec(pulse[7]), .key_sel_sal(pulse[8]), .key_sel_main(pulse[9]),
    .key_sel_lstat(pulse[10]), .key_sel_ip(pulse[11]), .key_sel_gpr(pulse[12]),
    .key_gpr_num(val[2:0]), .key_sel_addr_key(pulse[13]), .key_level(pulse[14]),
    .key_level_num(val[1:0]), .key_hex(pulse[15]), .key_hex_val(val),
    .display_data(display_data), .level_ind(level_ind), .stop_ind(stop_ind), .tone(tone),
    .console_irq(console_irq), .start_addr(start_addr), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  // Free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Count one-cycle tone and interrupt pulses
  always @(posedge clk_sys) begin
    if (tone === 1'b1) tones++;
    if (console_irq === 1'b1) irqs++;
  end
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    conclude();
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Single word transfer; waits for the slave in both phases
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Press a key and let its effect and tone land
  task automatic k(input int idx, input logic [3:0] v);
    op.press(idx, v);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task automatic tn(input int idx, input int n);
    t0 = tones;
    k(idx, 4'h0);
    chk(tones - t0, n);
  endtask
  task automatic enter(input logic [15:0] w);
    for (int i = 3; i >= 0; i--) k(15, w[i*4+:4]);
  endtask
  task automatic irq_try(input logic [7:0] summ, input int n);
    ahb(1'b1, OFS_SUMMARY, {31'h0, summ[0]});
    t0 = irqs;
    op.hold(1'b1);
    repeat (4) @(posedge clk_sys);
    op.hold(1'b0);
    repeat (2) @(posedge clk_sys);
    chk(irqs - t0, n);
  endtask
  // Key held first, program enables the summary mask afterwards
  task automatic irq_late();
    ahb(1'b1, OFS_SUMMARY, 32'h0);
    t0 = irqs;
    op.hold(1'b1);
    repeat (3) @(posedge clk_sys);
    ahb(1'b1, OFS_SUMMARY, 32'h1);
    repeat (3) @(posedge clk_sys);
    op.hold(1'b0);
    repeat (2) @(posedge clk_sys);
    chk(irqs - t0, 1);
  endtask
  task automatic t_reset();
    chk({display_data, 3'h0, stop_ind, level_ind}, 32'h00FFFF10);
    enter(16'hF3A8);
    chk(display_data, 16'hF3A8);
    k(KRST, 4'h0);
    chk({stop_ind, level_ind}, 5'h11);
    k(KBUF, 4'h0);
    chk(display_data, 16'hF3A8);
    ahb(1'b0, OFS_INT_MASK, 32'h0);
    chk(rd, 32'h0000000F);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[4:0], 5'h12);
    k(KLST, 4'h0);
    chk(display_data, 16'h0700);
    k(KEX, 4'h0);
    chk(display_data, 16'h0000);
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic t_refuse();
    k(KSWD, 4'h0);
    enter(16'hBEEF);
    tn(KSTO, 0);
    ahb(1'b0, OFS_STATUS_WORD, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, OFS_IWORD, 32'h00005A5A);
    k(KIW, 4'h0);
    chk(display_data, 16'h5A5A);
    tn(KSTO, 0);
    ahb(1'b0, OFS_IWORD, 32'h0);
    chk(rd, 32'h00005A5A);
    k(KLST, 4'h0);
    tn(KSTO, 0);
    tn(KADK, 0);
  endtask
  task automatic t_store();
    k(KSAL, 4'h0);
    enter(16'h8010);
    tn(KSTO, 1);
    k(KSAL, 4'h0);
    chk(display_data, 16'h0010);
    k(KMAIN, 4'h0);
    enter(16'h1234);
    k(KSTO, 4'h0);
    k(KSTO, 4'h0);
    k(KSAL, 4'h0);
    chk(display_data, 16'h0012);
    enter(16'h0010);
    k(KSTO, 4'h0);
    k(KMAIN, 4'h0);
    chk(display_data, 16'h1234);
    k(KMAIN, 4'h0);
    k(KSAL, 4'h0);
    chk(display_data, 16'h0012);
  endtask
  task automatic t_levels();
    for (int l = 0; l < 4; l++) begin
      k(KLVL, l[3:0]);
      k(KGPR, 4'h3);
      enter(16'h00C0 + l[15:0]);
      k(KSTO, 4'h0);
    end
    chk(level_ind, 4'h8);
    for (int l = 0; l < 4; l++) begin
      k(KLVL, l[3:0]);
      k(KGPR, 4'h3);
      chk(display_data, 16'h00C0 + l[15:0]);
    end
  endtask
  task automatic t_run();
    k(KSTA, 4'h0);
    chk({stop_ind, start_addr}, 17'h00000);
    tn(KSTO, 0);
    irq_try(8'h00, 0);
    irq_try(8'h01, 1);
    irq_late();
    ahb(1'b1, OFS_CPU_EVENT, 32'h1);
    k(KSTP, 4'h0);
    k(KSTA, 4'h0);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[1:0], 2'h1);
    ahb(1'b1, OFS_CPU_EVENT, 32'h2);
    k(KSTP, 4'h0);
    irq_try(8'h01, 0);
    k(KIP, 4'h0);
    enter(16'h8123);
    k(KSTO, 4'h0);
    k(KIP, 4'h0);
    chk(display_data, 16'h0123);
    k(KSTA, 4'h0);
    chk({stop_ind, start_addr}, 17'h00123);
    chk(display_data, 16'h8123);
    k(KSTP, 4'h0);
    chk(display_data, 16'h0123);
    k(KEX, 4'h0);
    chk(display_data, 16'h0123);
    k(KBUF, 4'h0);
    chk(display_data, 16'h8123);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_refuse();
    t_store();
    t_levels();
    t_run();
    conclude();
  end
endmodule // testbench
`default_nettype wire
